// ===== design/rxdma_pkg.sv
package rxdma_pkg;
   // register byte offsets on the control slave
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_BASE = 4'h4;
   localparam logic [3:0] REG_STOP = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hC;
   // control register fields
   localparam int CTRL_INIT_BIT = 0;
   localparam int CTRL_MODE_BIT = 1;
   // descriptor word byte offsets from the descriptor address
   localparam logic [31:0] DW4_OFS = 32'h0000_000C;
   localparam logic [31:0] DW5_OFS = 32'h0000_0010;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   // first descriptor word fields
   localparam int D1_HOLD_BIT = 31;
   localparam int D1_HIRQ_BIT = 30;
   // fourth descriptor word fields
   localparam int D4_FE_BIT = 31;
   localparam int D4_C_BIT = 30;
   localparam int D4_STAT_LSB = 16;
   // header burst length and reset values
   localparam logic [3:0] HDR_BURST = 4'h3;
   localparam logic [1:0] HDR_LAST = 2'h2;
   localparam logic [3:0] ONE_BEAT = 4'h1;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   // channel status byte codes
   localparam logic [7:0] END_NORMAL = 8'h00;
   localparam logic [7:0] END_RESET = 8'h01;
   localparam logic [7:0] END_HOLD = 8'h02;
   // channel sequencer states
   typedef enum logic [3:0] {
      RXDMA_IDLE,
      RXDMA_FETCH,
      RXDMA_HDR,
      RXDMA_DATA,
      RXDMA_WDATA,
      RXDMA_W4,
      RXDMA_W5,
      RXDMA_DONE,
      RXDMA_HALT
   } rxdma_state_t;
endpackage

// ===== design/rxdma_top.sv
module rxdma_top
   import rxdma_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // avalon control slave
   input wire logic [3:0] s_address_i,
   input wire logic s_read_i,
   input wire logic s_write_i,
   input wire logic [31:0] s_writedata_i,
   output logic [31:0] s_readdata_o,
   output logic s_waitrequest_o,
   // avalon memory master
   output logic [31:0] m_address_o,
   output logic m_read_o,
   output logic m_write_o,
   output logic [3:0] m_burstcount_o,
   output logic [31:0] m_writedata_o,
   output logic [3:0] m_byteenable_o,
   input wire logic [31:0] m_readdata_i,
   input wire logic m_readdatavalid_i,
   input wire logic m_waitrequest_i,
   // receive fifo words from the serial controller
   input wire logic [31:0] rx_word_i,
   input wire logic [2:0] rx_nbytes_i,
   input wire logic rx_end_i,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   input wire logic rx_abort_i,
   // event pulses toward the interrupt queue
   output logic packet_done_irq_o,
   output logic host_irq_o,
   output logic stop_irq_o
);
   // reset synchroniser, first stage read only by second
   logic rst_meta;
   logic rst_sync;
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         {rst_sync, rst_meta} <= 2'b00;
      else
         {rst_sync, rst_meta} <= {rst_meta, 1'b1};
   end
   wire rst_n = rst_sync;
   // software registers
   logic [31:0] base_descriptor_address; // list head
   logic [31:0] stop_descriptor_address; // stop compare value
   logic list_stop_select; // 1: compare addresses, 0: chain flag
   logic init_req; // one-cycle init pulse
   logic s_served; // slave answered this cycle
   // channel state
   rxdma_state_t state;
   logic [31:0] cur_addr; // current descriptor address
   logic [31:0] first_addr; // descriptor holding frame start
   logic [31:0] next_addr; // second descriptor word
   logic [31:0] buf_addr; // third descriptor word, advances
   logic [15:0] buf_size; // capacity in bytes
   logic [15:0] buf_ofs; // bytes of space used (word steps)
   logic [15:0] stored_byte_count; // valid bytes stored
   logic hold_flag; // chain-stop flag of current descriptor
   logic hirq_flag; // host interrupt request of descriptor
   logic in_frame; // a frame has started in memory
   logic frame_last_flag; // closing descriptor holds frame end
   logic [7:0] frame_status_byte; // channel end code
   logic w5_pending; // fifth word still to write
   logic w4_written; // fourth word already out
   logic [1:0] beat; // header beat counter
   logic [31:0] wdata_q; // latched fifo word
   logic [3:0] be_q; // latched byte enables
   logic end_q; // latched frame end
   // byte enable for a partial word; holes stay unwritten
   function automatic logic [3:0] be_of(input logic [2:0] n);
      case (n)
         3'd1: be_of = 4'b0001;
         3'd2: be_of = 4'b0011;
         3'd3: be_of = 4'b0111;
         default: be_of = 4'b1111;
      endcase
   endfunction
   // slave decode: one wait cycle, then answer
   wire s_req = s_read_i | s_write_i;
   wire s_hit_ctrl = s_address_i == REG_CTRL;
   wire s_hit_base = s_address_i == REG_BASE;
   wire s_hit_stop = s_address_i == REG_STOP;
   wire s_hit_stat = s_address_i == REG_STAT;
   // a write lands only on the edge after the wait cycle, when waitrequest is low, as the master expects
   wire s_wr_now = s_write_i & s_served;
   assign s_waitrequest_o = s_req & ~s_served;
   // register read mux; unmapped reads return zero
   // the count sits above the flags so a large count never masks them
   wire [31:0] stat_word = {stored_byte_count, 6'h00, in_frame, state == RXDMA_HALT,
                            state != RXDMA_IDLE && state != RXDMA_HALT, 7'h00};
   wire [31:0] rd_mux = s_hit_ctrl ? {30'h0000_0000, list_stop_select, 1'b0} :
                        s_hit_base ? base_descriptor_address :
                        s_hit_stop ? stop_descriptor_address :
                        s_hit_stat ? stat_word : 32'h0000_0000;
   // slave registers, written on the answering edge
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_served <= 1'b0;
         s_readdata_o <= 32'h0000_0000;
         base_descriptor_address <= ADDR_RST;
         stop_descriptor_address <= ADDR_RST;
         list_stop_select <= 1'b0;
         init_req <= 1'b0;
      end
      else
      begin
         s_served <= s_req & ~s_served;
         init_req <= 1'b0;
         if (s_read_i && !s_served)
            s_readdata_o <= rd_mux;
         if (s_wr_now && s_hit_ctrl)
         begin
            list_stop_select <= s_writedata_i[CTRL_MODE_BIT];
            init_req <= s_writedata_i[CTRL_INIT_BIT];
         end
         if (s_wr_now && s_hit_base)
            base_descriptor_address <= s_writedata_i;
         if (s_wr_now && s_hit_stop)
            stop_descriptor_address <= s_writedata_i;
      end
   end
   // stop condition of the current descriptor
   // descriptor flag ignored when list_stop_select is 1
   wire stop_now = list_stop_select ? (cur_addr == stop_descriptor_address) : hold_flag;
   wire buf_full = (buf_ofs + 16'h0004) > buf_size;
   wire single_sec = first_addr == cur_addr;
   wire m_ack = (m_read_o | m_write_o) & ~m_waitrequest_i;
   wire take_word = state == RXDMA_DATA && !buf_full && rx_valid_i;
   assign rx_ready_o = state == RXDMA_DATA && !buf_full;
   // fourth word image
   // frame last flag
   wire [31:0] dw4 = {frame_last_flag, 1'b1, 6'h00, frame_status_byte, stored_byte_count};
   // channel sequencer
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= RXDMA_IDLE;
         cur_addr <= ADDR_RST;
         first_addr <= ADDR_RST;
         next_addr <= ADDR_RST;
         buf_addr <= ADDR_RST;
         buf_size <= CNT_RST;
         buf_ofs <= CNT_RST;
         stored_byte_count <= CNT_RST;
         hold_flag <= 1'b0;
         hirq_flag <= 1'b0;
         in_frame <= 1'b0;
         frame_last_flag <= 1'b0;
         frame_status_byte <= END_NORMAL;
         w5_pending <= 1'b0;
         w4_written <= 1'b0;
         beat <= 2'h0;
         wdata_q <= 32'h0000_0000;
         be_q <= 4'h0;
         end_q <= 1'b0;
         m_address_o <= ADDR_RST;
         m_read_o <= 1'b0;
         m_write_o <= 1'b0;
         m_burstcount_o <= ONE_BEAT;
         m_writedata_o <= 32'h0000_0000;
         m_byteenable_o <= 4'h0;
         packet_done_irq_o <= 1'b0;
         host_irq_o <= 1'b0;
         stop_irq_o <= 1'b0;
      end
      else
      begin
         packet_done_irq_o <= 1'b0;
         host_irq_o <= 1'b0;
         stop_irq_o <= 1'b0;
         if (init_req)
         begin
            cur_addr <= base_descriptor_address;
            in_frame <= 1'b0;
            m_read_o <= 1'b0;
            m_write_o <= 1'b0;
            state <= RXDMA_FETCH;
         end
         else
         begin
            case (state)
               RXDMA_FETCH:
               begin
                  m_address_o <= cur_addr;
                  m_burstcount_o <= HDR_BURST;
                  m_read_o <= 1'b1;
                  beat <= 2'h0;
                  state <= RXDMA_HDR;
               end
               // collect header beats
               RXDMA_HDR:
               begin
                  if (m_ack)
                     m_read_o <= 1'b0;
                  if (m_readdatavalid_i)
                  begin
                     beat <= beat + 2'h1;
                     case (beat)
                        2'h0:
                        begin
                           hold_flag <= m_readdata_i[D1_HOLD_BIT];
                           hirq_flag <= m_readdata_i[D1_HIRQ_BIT];
                           buf_size <= m_readdata_i[15:0];
                        end
                        2'h1: next_addr <= m_readdata_i;
                        default: buf_addr <= m_readdata_i;
                     endcase
                     if (beat == HDR_LAST)
                     begin
                        buf_ofs <= CNT_RST;
                        stored_byte_count <= CNT_RST;
                        frame_last_flag <= 1'b0;
                        w4_written <= 1'b0;
                        state <= RXDMA_DATA;
                     end
                  end
               end
               // wait for fifo data or close a full buffer
               RXDMA_DATA:
               begin
                  if (buf_full)
                  begin
                     frame_status_byte <= stop_now ? END_HOLD : END_NORMAL;
                     state <= RXDMA_W4;
                  end
                  else if (take_word)
                  begin
                     wdata_q <= rx_word_i;
                     be_q <= be_of(rx_nbytes_i);
                     end_q <= rx_end_i;
                     if (!in_frame)
                        first_addr <= cur_addr;
                     in_frame <= 1'b1;
                     state <= RXDMA_WDATA;
                  end
                  else if (rx_abort_i && in_frame)
                  begin
                     frame_last_flag <= 1'b1;
                     frame_status_byte <= END_RESET;
                     w5_pending <= 1'b1;
                     state <= single_sec ? RXDMA_W4 : RXDMA_W5;
                  end
               end
               RXDMA_WDATA:
               begin
                  if (!m_write_o)
                  begin
                     m_address_o <= buf_addr;
                     m_burstcount_o <= ONE_BEAT;
                     m_writedata_o <= wdata_q;
                     m_byteenable_o <= be_q;
                     m_write_o <= 1'b1;
                  end
                  else if (m_ack)
                  begin
                     m_write_o <= 1'b0;
                     buf_addr <= buf_addr + WORD_STEP;
                     buf_ofs <= buf_ofs + 16'h0004;
                     stored_byte_count <= stored_byte_count + {13'h0000, rx_nbytes_of(be_q)};
                     if (end_q)
                     begin
                        frame_last_flag <= 1'b1;
                        frame_status_byte <= stop_now ? END_HOLD : END_NORMAL;
                        w5_pending <= 1'b1;
                        state <= single_sec ? RXDMA_W4 : RXDMA_W5;
                     end
                     else
                        state <= RXDMA_DATA;
                  end
               end
               RXDMA_W4:
               begin
                  if (!m_write_o)
                  begin
                     m_address_o <= cur_addr + DW4_OFS;
                     m_burstcount_o <= ONE_BEAT;
                     m_writedata_o <= dw4;
                     m_byteenable_o <= 4'hF;
                     m_write_o <= 1'b1;
                  end
                  else if (m_ack)
                  begin
                     m_write_o <= 1'b0;
                     w4_written <= 1'b1;
                     state <= w5_pending ? RXDMA_W5 : RXDMA_DONE;
                  end
               end
               RXDMA_W5:
               begin
                  if (!m_write_o)
                  begin
                     m_address_o <= first_addr + DW5_OFS;
                     m_burstcount_o <= ONE_BEAT;
                     m_writedata_o <= cur_addr;
                     m_byteenable_o <= 4'hF;
                     m_write_o <= 1'b1;
                  end
                  else if (m_ack)
                  begin
                     m_write_o <= 1'b0;
                     w5_pending <= 1'b0;
                     in_frame <= 1'b0;
                     state <= w4_written ? RXDMA_DONE : RXDMA_W4;
                  end
               end
               // descriptor finished: events and branch
               RXDMA_DONE:
               begin
                  packet_done_irq_o <= frame_last_flag;
                  host_irq_o <= hirq_flag;
                  if (stop_now)
                  begin
                     stop_irq_o <= 1'b1;
                     state <= RXDMA_HALT;
                  end
                  else
                  begin
                     cur_addr <= next_addr;
                     state <= RXDMA_FETCH;
                  end
               end
               // idle before the first init, inactive after a stop until init
               RXDMA_IDLE, RXDMA_HALT:
               begin
                  state <= state;
               end
               default:
               begin
                  state <= RXDMA_IDLE;
               end
            endcase
         end
      end
   end
   // valid byte count from enables
   function automatic logic [2:0] rx_nbytes_of(input logic [3:0] be);
      rx_nbytes_of = {2'b00, be[0]} + {2'b00, be[1]} + {2'b00, be[2]} + {2'b00, be[3]};
   endfunction
endmodule

// ===== tb/rxdma_sva.sv
module rxdma_sva
   import rxdma_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // control slave
   input wire logic s_read_i,
   input wire logic s_write_i,
   input wire logic s_waitrequest_o,
   // memory master
   input wire logic [31:0] m_address_o,
   input wire logic m_read_o,
   input wire logic m_write_o,
   input wire logic [3:0] m_burstcount_o,
   input wire logic [31:0] m_writedata_o,
   input wire logic [3:0] m_byteenable_o,
   input wire logic m_waitrequest_i,
   // receive side and events
   input wire logic [2:0] rx_nbytes_i,
   input wire logic rx_valid_i,
   input wire logic rx_ready_o,
   input wire logic packet_done_irq_o,
   input wire logic stop_irq_o
);
   // one domain, so clock and reset are stated once
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   property p_slave_wait;
      $rose(s_read_i || s_write_i) |-> s_waitrequest_o ##1 !s_waitrequest_o;
   endproperty
   a_slave_wait: assert property (p_slave_wait) else $error("slave answer not after one wait");
   property p_hdr_burst;
      m_read_o |-> m_burstcount_o == HDR_BURST;
   endproperty
   a_hdr_burst: assert property (p_hdr_burst) else $error("header read not a three beat burst");
   property p_wr_single;
      m_write_o |-> m_burstcount_o == ONE_BEAT && m_address_o[1:0] == 2'b00;
   endproperty
   a_wr_single: assert property (p_wr_single) else $error("write not a single aligned word");
   property p_read_hold;
      m_read_o && m_waitrequest_i |=> m_read_o && $stable(m_address_o);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read released while stalled");
   property p_write_hold;
      m_write_o && m_waitrequest_i |=> m_write_o && $stable(m_address_o) && $stable(m_writedata_o)
         && $stable(m_byteenable_o);
   endproperty
   a_write_hold: assert property (p_write_hold) else $error("write changed while stalled");
   property p_part_word;
      rx_valid_i && rx_ready_o && rx_nbytes_i == 3'h1 |-> ##[1:60] m_write_o && m_byteenable_o == 4'h1;
   endproperty
   a_part_word: assert property (p_part_word) else $error("one byte word not written with one lane");
   property p_irq_pulse;
      packet_done_irq_o |=> !packet_done_irq_o;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("done event longer than a cycle");
   property p_stop_quiet;
      stop_irq_o |=> (!m_read_o && !m_write_o && !rx_ready_o) [*8];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("channel active after stop");
endmodule

bind rxdma_top rxdma_sva u_sva (.*);

// ===== tb/rxdma_mem_model.sv
module rxdma_mem_model (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // requests from the channel
   input wire logic [31:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [3:0] burst_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] be_i,
   // answers to the channel
   output logic [31:0] rdata_o,
   output logic rvalid_o,
   output logic wait_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // host memory holds aligned words only, so the index drops the byte bits
   logic [31:0] mem [0:255];
   logic [31:0] last_rd, last_wr, prev_wr; // access history for the bench
   logic [15:0] lfsr; // stall pattern
   logic [3:0] beats; // header beats still owed
   logic [7:0] ptr; // next word of a burst
   // stall about a quarter of cycles so the hold logic is exercised
   assign wait_o = lfsr[0] & lfsr[5];
   // beats go out one per cycle; idle data is inverted so it never looks valid
   always @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         lfsr <= 16'hace1;
         beats <= 4'h0;
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
      end
      else
      begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         rvalid_o <= (beats != 4'h0);
         rdata_o <= (beats != 4'h0) ? mem[ptr] : ~rdata_o;
         if (beats != 4'h0)
         begin
            beats <= beats - 4'h1;
            ptr <= ptr + 8'h01;
         end
         else if (read_i && !wait_o)
         begin
            beats <= burst_i;
            ptr <= address_i[9:2];
            last_rd <= address_i;
         end
         // byte lanes follow the enables, holes keep old contents
         if (write_i && !wait_o)
         begin
            for (int b = 0; b < 4; b++)
               if (be_i[b])
                  mem[address_i[9:2]][8*b +: 8] <= wdata_i[8*b +: 8];
            prev_wr <= last_wr;
            last_wr <= address_i;
         end
      end
   end
endmodule

// ===== tb/testbench.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rxdma_pkg::*;
   // design inputs
   logic mclk_i, resetn_i, s_read_i, s_write_i, rx_end_i, rx_valid_i, rx_abort_i;
   logic [3:0] s_address_i;
   logic [31:0] s_writedata_i, rx_word_i;
   logic [2:0] rx_nbytes_i;
   // design outputs and memory wires
   logic [31:0] s_readdata_o, m_address_o, m_writedata_o, m_readdata_i;
   logic s_waitrequest_o, m_read_o, m_write_o, m_readdatavalid_i, m_waitrequest_i, rx_ready_o;
   logic [3:0] m_burstcount_o, m_byteenable_o;
   logic packet_done_irq_o, host_irq_o, stop_irq_o;
   // bench bookkeeping
   int n_mismatch, comparisons, n_done, n_host, n_stop;
   logic [31:0] seed, q, r0, r1, r2;
   rxdma_top DUT (.*);
   rxdma_mem_model u_mem (.mclk_i(mclk_i), .resetn_i(resetn_i), .address_i(m_address_o), .read_i(m_read_o),
      .write_i(m_write_o), .burst_i(m_burstcount_o), .wdata_i(m_writedata_o), .be_i(m_byteenable_o),
      .rdata_o(m_readdata_i), .rvalid_o(m_readdatavalid_i), .wait_o(m_waitrequest_i));
   // 20 MHz clock
   initial
   begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   // event pulses are one cycle, so counting at every edge sees each once
   always @(posedge mclk_i)
   begin
      if (packet_done_irq_o === 1'b1) n_done++;
      if (host_irq_o === 1'b1) n_host++;
      if (stop_irq_o === 1'b1) n_stop++;
   end
   // xorshift keeps the run repeatable
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // expected completion word of a descriptor that ended normally
   function automatic logic [31:0] w4(input logic fl, input logic [15:0] cnt);
      return {fl, 1'b1, 6'h00, END_NORMAL, cnt};
   endfunction
   task automatic close_out;
      $display("counts: %0d compares, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one slave access, held until waitrequest is seen low
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      s_address_i <= a;
      s_writedata_i <= d;
      s_write_i <= we;
      s_read_i <= ~we;
      do @(posedge mclk_i); while (s_waitrequest_o !== 1'b0);
      q = s_readdata_o;
      s_read_i <= 1'b0;
      s_write_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   // one fifo word after a random gap; the line is scrambled once released
   task automatic send(input logic [31:0] w, input logic [2:0] nb, input logic e);
      repeat (1 + seed[1:0]) @(posedge mclk_i);
      rx_word_i <= w;
      rx_nbytes_i <= nb;
      rx_end_i <= e;
      rx_valid_i <= 1'b1;
      do @(posedge mclk_i); while (rx_ready_o !== 1'b1);
      rx_valid_i <= 1'b0;
      rx_word_i <= ~w;
      seed = xs(seed);
   endtask
   // bounded wait for an event count
   task automatic await(ref int c, input int t);
      for (int n = 0; n < 3000 && c < t; n++) @(posedge mclk_i);
   endtask
   // five aligned words, sizes kept a multiple of four
   task automatic desc(input logic [31:0] a, w1, nx, bf);
      u_mem.mem[a[9:2]] = w1;
      u_mem.mem[a[9:2] + 8'h01] = nx;
      u_mem.mem[a[9:2] + 8'h02] = bf;
      u_mem.mem[a[9:2] + 8'h03] = 32'h5a5a_5a5a;
      u_mem.mem[a[9:2] + 8'h04] = 32'h5a5a_5a5a;
   endtask
   // watchdog: the whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      n_mismatch++;
      close_out();
   end
   initial
   begin
      // every input defined at time zero, reset held ten cycles
      {resetn_i, s_read_i, s_write_i, rx_end_i, rx_valid_i, rx_abort_i} = 6'h00;
      s_address_i = 4'h0;
      s_writedata_i = 32'h0000_0000;
      rx_word_i = 32'h0000_0000;
      rx_nbytes_i = 3'h4;
      seed = 32'h0000_6d34;
      repeat (10) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      // registers, including an unmapped offset
      bus(1'b1, REG_BASE, 32'h0000_0100);
      bus(1'b1, REG_STOP, 32'h0000_0abc);
      bus(1'b0, REG_BASE, 32'h0000_0000); `CHK(q, 32'h0000_0100)
      bus(1'b0, REG_STOP, 32'h0000_0000); `CHK(q, 32'h0000_0abc)
      bus(1'b1, 4'h2, 32'hffff_ffff);
      bus(1'b0, 4'h2, 32'h0000_0000); `CHK(q, 32'h0000_0000)
      $display("test registers done");
      // single section frame with host interrupt, then a list ending in a stop
      desc(32'h0000_0100, 32'h4000_0010, 32'h0000_0140, 32'h0000_0200);
      desc(32'h0000_0140, 32'h0000_0008, 32'h0000_0180, 32'h0000_0240);
      desc(32'h0000_0180, 32'h8000_0010, 32'h0000_01c0, 32'h0000_0280);
      u_mem.mem[8'h81] = 32'hffff_ffff;
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      r0 = seed; send(r0, 3'h4, 1'b0);
      r1 = seed; send(r1, 3'h3, 1'b1);
      await(n_done, 1);
      `CHK(u_mem.mem[8'h80], r0)
      `CHK(u_mem.mem[8'h81], {8'hff, r1[23:0]})
      `CHK(u_mem.mem[8'h43], w4(1'b1, 16'h0007))
      `CHK(u_mem.mem[8'h44], 32'h0000_0100)
      `CHK(u_mem.prev_wr, 32'h0000_010c)
      `CHK(u_mem.last_wr, 32'h0000_0110)
      `CHK(n_host, 1)
      $display("test single section done");
      // frame spills over an eight byte buffer into the stopping descriptor
      r0 = seed; send(r0, 3'h4, 1'b0);
      r1 = seed; send(r1, 3'h4, 1'b0);
      r2 = seed; send(r2, 3'h4, 1'b1);
      await(n_stop, 1);
      `CHK(u_mem.mem[8'h90], r0)
      `CHK(u_mem.mem[8'h91], r1)
      `CHK(u_mem.mem[8'ha0], r2)
      `CHK({u_mem.mem[8'h53][31:30], u_mem.mem[8'h53][15:0]}, {2'b01, 16'h0008})
      `CHK(u_mem.mem[8'h54], 32'h0000_0180)
      `CHK({u_mem.mem[8'h63][31:30], u_mem.mem[8'h63][15:0]}, {2'b11, 16'h0004})
      `CHK(u_mem.prev_wr, 32'h0000_0150)
      `CHK(u_mem.last_wr, 32'h0000_018c)
      `CHK(n_done, 2)
      bus(1'b0, REG_STAT, 32'h0000_0000); `CHK(q[8], 1'b1)
      `CHK(u_mem.last_rd, 32'h0000_0180)
      $display("test chain stop done");
      // stop by address: descriptor flag ignored, stop at the programmed place
      desc(32'h0000_0100, 32'h8000_0010, 32'h0000_0140, 32'h0000_0200);
      desc(32'h0000_0140, 32'h0000_0008, 32'h0000_0180, 32'h0000_0240);
      bus(1'b1, REG_STOP, 32'h0000_0140);
      bus(1'b1, REG_BASE, 32'h0000_0100);
      bus(1'b1, REG_CTRL, 32'h0000_0003);
      r0 = seed; send(r0, 3'h1, 1'b1);
      await(n_done, 3);
      `CHK(u_mem.mem[8'h43], w4(1'b1, 16'h0001))
      for (int n = 0; n < 500 && u_mem.last_rd !== 32'h0000_0140; n++) @(posedge mclk_i);
      `CHK(u_mem.last_rd, 32'h0000_0140)
      `CHK(n_stop, 1)
      r1 = seed; send(r1, 3'h2, 1'b1);
      await(n_stop, 2);
      `CHK(u_mem.mem[8'h90][15:0], r1[15:0])
      `CHK(u_mem.mem[8'h54], 32'h0000_0140)
      `CHK(n_stop, 2)
      $display("test address stop done");
      // receiver reset cuts a frame short; stop address holds the channel at the head
      desc(32'h0000_0100, 32'h0000_0010, 32'h0000_0140, 32'h0000_0200);
      bus(1'b1, REG_STOP, 32'h0000_0100);
      bus(1'b1, REG_CTRL, 32'h0000_0003);
      r0 = seed; send(r0, 3'h4, 1'b0);
      rx_abort_i <= 1'b1;
      await(n_stop, 3);
      rx_abort_i <= 1'b0;
      `CHK(u_mem.mem[8'h43], {2'b11, 6'h00, END_RESET, 16'h0004})
      `CHK(u_mem.mem[8'h44], 32'h0000_0100)
      `CHK(n_stop, 3)
      $display("test receiver reset done");
      close_out();
   end
endmodule
